//--- rtl/dmsci_pkg.sv
// Purpose: Shared constants and types for the dual mode serial comm interface.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes:   Every width, code and count used by more than one file lives here.
package dmsci_pkg;

	// ****************************************************************
	// Operating modes and clock sources
	// ****************************************************************
	typedef enum logic [1:0]
	{
		DMSCI_MODE_ASYNC = 2'h0,
		DMSCI_MODE_MULTI = 2'h1,
		DMSCI_MODE_SYNC  = 2'h2
	} dmsci_mode_e;

	typedef enum logic [1:0]
	{
		DMSCI_CLK_BAUD  = 2'h0,
		DMSCI_CLK_EXT   = 2'h1,
		DMSCI_CLK_TIMER = 2'h2
	} dmsci_clksel_e;

	// ****************************************************************
	// Widths and timing counts
	// ****************************************************************
	localparam int unsigned DMSCI_DATA_W   = 8;
	localparam int unsigned DMSCI_FIFO_D   = 32;
	localparam int unsigned DMSCI_OVS      = 16;
	localparam logic [3:0]  DMSCI_OVS_MID  = 4'h7;
	localparam logic [3:0]  DMSCI_OVS_LAST = 4'hf;
	localparam logic [3:0]  DMSCI_BITS_7   = 4'h7;
	localparam logic [3:0]  DMSCI_BITS_8   = 4'h8;
	localparam int unsigned DMSCI_CLK_HZ   = 100000000;
	localparam int unsigned DMSCI_DIV_W    = 16;

	// Baud choices; divisor is clock over (rate times oversampling).
	localparam int unsigned DMSCI_ASYNC_BPS_0 = 31250;
	localparam int unsigned DMSCI_ASYNC_BPS_1 = 9615;
	localparam int unsigned DMSCI_ASYNC_BPS_2 = 4808;
	localparam int unsigned DMSCI_ASYNC_BPS_3 = 2404;
	localparam int unsigned DMSCI_ASYNC_BPS_4 = 1202;
	localparam int unsigned DMSCI_SYNC_BPS_0  = 1000000;
	localparam int unsigned DMSCI_SYNC_BPS_1  = 500000;
	localparam int unsigned DMSCI_SYNC_BPS_2  = 250000;
	localparam int unsigned DMSCI_SYNC_BPS_3  = 125000;
	localparam int unsigned DMSCI_SYNC_BPS_4  = 62500;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed
	{
		logic frame_err;
		logic overrun_err;
		logic parity_err;
	} dmsci_err_s;

	typedef struct packed
	{
		dmsci_mode_e   mode;
		dmsci_clksel_e clk_sel;
		logic [2:0]    baud_sel;
		logic          parity_en;
		logic          parity_odd;
		logic          two_stop;
	} dmsci_cfg_s;

endpackage

//--- rtl/dmsci_fifo.sv
// Purpose: Valid/ready FIFO in the transmit data path.
// Assumes: Same clock on both sides.
// Notes:   Full and empty come from a count so both are exact.
module dmsci_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
)(
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} dmsci_fifo_s;

	dmsci_fifo_s      st_reg;
	dmsci_fifo_s      st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.cnt != '0);
	assign out_data  = mem[st_reg.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap naturally because depth is a power of two.
	always_comb
	begin
		st_next = st_reg;
		if (push)
			st_next.wr = st_reg.wr + 1'b1;
		if (pop)
			st_next.rd = st_reg.rd + 1'b1;
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register and storage write.
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
		if (push)
			mem[st_reg.wr] <= in_data;
	end

	chk_fifo_no_over: assert property (@(posedge sys_clk) disable iff (!rst_b)
		st_reg.cnt <= (AW+1)'(DEPTH))
		else $error("FIFO count above depth.");
endmodule

//--- rtl/dmsci_baud.sv
// Purpose: Oversampling tick generator from a selectable bit clock source.
// Assumes: External and timer clock inputs already synchronised by the caller.
// Notes:   Outside sources give one tick per rising edge, taken as x16 ticks.
module dmsci_baud (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// Configuration
	input  dmsci_pkg::dmsci_cfg_s      cfg,
	// Outside clock sources, synchronised levels
	input  wire logic                  ext_clk_sync,
	input  wire logic                  tmr_clk_sync,
	// Oversampling tick
	output logic                       os_tick
);
	typedef struct packed
	{
		logic [dmsci_pkg::DMSCI_DIV_W-1:0] cnt;
		logic                              ext_d;
		logic                              tmr_d;
		logic                              tick;
	} dmsci_baud_s;

	dmsci_baud_s st_reg;
	dmsci_baud_s st_next;

	// Divisor for the selected rate; async and sync tables share one index.
	function automatic logic [dmsci_pkg::DMSCI_DIV_W-1:0] div_of(input logic sync,
		input logic [2:0] sel);
		int unsigned bps;
		case (sel)
			3'h0: bps = sync ? dmsci_pkg::DMSCI_SYNC_BPS_0 : dmsci_pkg::DMSCI_ASYNC_BPS_0;
			3'h1: bps = sync ? dmsci_pkg::DMSCI_SYNC_BPS_1 : dmsci_pkg::DMSCI_ASYNC_BPS_1;
			3'h2: bps = sync ? dmsci_pkg::DMSCI_SYNC_BPS_2 : dmsci_pkg::DMSCI_ASYNC_BPS_2;
			3'h3: bps = sync ? dmsci_pkg::DMSCI_SYNC_BPS_3 : dmsci_pkg::DMSCI_ASYNC_BPS_3;
			default: bps = sync ? dmsci_pkg::DMSCI_SYNC_BPS_4 : dmsci_pkg::DMSCI_ASYNC_BPS_4;
		endcase
		return dmsci_pkg::DMSCI_DIV_W'(dmsci_pkg::DMSCI_CLK_HZ
			/ (bps * dmsci_pkg::DMSCI_OVS) - 1);
	endfunction

	// Tick generation from the selected source. [R14] [R15] [R16]
	always_comb
	begin
		st_next       = st_reg;
		st_next.ext_d = ext_clk_sync;
		st_next.tmr_d = tmr_clk_sync;
		st_next.tick  = 1'b0;
		case (cfg.clk_sel)
			dmsci_pkg::DMSCI_CLK_EXT:
				st_next.tick = ext_clk_sync && !st_reg.ext_d;
			dmsci_pkg::DMSCI_CLK_TIMER:
				st_next.tick = tmr_clk_sync && !st_reg.tmr_d;
			default:
			begin
				if (st_reg.cnt == '0)
				begin
					st_next.cnt  = div_of(cfg.mode == dmsci_pkg::DMSCI_MODE_SYNC,
						cfg.baud_sel);
					st_next.tick = 1'b1;
				end
				else
					st_next.cnt = st_reg.cnt - 1'b1;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign os_tick = st_reg.tick;
endmodule

//--- rtl/dmsci_top.sv
// Purpose: Dual mode serial comm interface: async, multiprocessor master, sync.
// Assumes: Single 100 MHz clock; serial and clock pins are asynchronous inputs.
// Notes:   Transmit data passes a 32-word FIFO; receive holds one buffered word.
//
// Functional notes
// R01 - Full duplex, double buffered, sync and async.
// R02 - Normal async: 7 bits with parity, else 8.
// R03 - Multiprocessor: eight data bits plus address bit.
// R04 - Eight data bits in multiprocessor and sync.
// R05 - No parity in multiprocessor or sync.
// R06 - Sync mode sends data bits only.
// R07 - Line uses NRZ in every mode.
// R08 - Bad stop bit flags framing error, async only.
// R09 - Parity checked only in normal async.
// R10 - Receive interrupt on completion or error.
// R11 - Transmit interrupt on character completion.
// R12 - Both interrupts can start auto transfer.
// R13 - Multiprocessor mode acts only as master.
// R14 - Bit clock from baud, external or timer.
// R15 - Async rates 31250 down to 1202 bps.
// R16 - Sync rates 1 Mbps down to 62.5 Kbps.
// R17 - Mode codes 0 async, 1 multi, 2 sync.
// R18 - Async receive detects start, samples mid-bit.
// R19 - Address bit one, data bit zero.
module dmsci_top (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	// Configuration
	input  dmsci_pkg::dmsci_cfg_s      cfg,
	input  wire logic                  ext_clk_in,
	input  wire logic                  tmr_clk_in,
	input  wire logic                  auto_xfer_en,
	// Transmit data from the core
	input  wire logic                  tx_valid,
	output logic                       tx_ready,
	input  wire logic [7:0]            tx_data,
	input  wire logic                  tx_addr,
	// Receive data to the core
	output logic                       rx_valid,
	input  wire logic                  rx_ack,
	output logic [7:0]                 rx_data,
	output dmsci_pkg::dmsci_err_s      rx_err,
	// Interrupt and transfer service requests
	output logic                       rx_irq,
	output logic                       tx_irq,
	output logic                       rx_auto_transfer_service,
	output logic                       tx_auto_transfer_service,
	// Serial pins
	input  wire logic                  rxd,
	output logic                       txd,
	output logic                       sck_out,
	output logic                       sck_oe
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic [1:0]
	{
		DMSCI_IDLE  = 2'b00,
		DMSCI_START = 2'b01,
		DMSCI_DATA  = 2'b11,
		DMSCI_STOP  = 2'b10
	} dmsci_fsm_e;

	typedef struct packed
	{
		logic [1:0] rxd_s;
		logic [1:0] ext_s;
		logic [1:0] tmr_s;
		dmsci_fsm_e tx_st;
		logic [3:0] tx_ph;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic       tx_stop2;
		logic       txd;
		logic       sck;
		logic       sck_oe;
		dmsci_fsm_e rx_st;
		logic [3:0] rx_ph;
		logic [3:0] rx_bit;
		logic [8:0] rx_sh;
		logic [7:0] rx_data;
		logic       rx_valid;
		dmsci_pkg::dmsci_err_s rx_err;
		logic       rx_irq;
		logic       tx_irq;
		logic       rx_ats;
		logic       tx_ats;
	} dmsci_top_s;

	dmsci_top_s  st_reg;
	dmsci_top_s  st_next;
	logic        os_tick;
	logic        f_valid;
	logic        f_ready;
	logic [8:0]  f_data;
	logic        is_sync;
	logic        is_multi;
	logic        par_on;
	logic [3:0]  nbits;

	// Payload bits per character for the configured mode. [R02] [R04]
	function automatic logic [3:0] data_bits(input dmsci_pkg::dmsci_cfg_s c);
		if (c.mode == dmsci_pkg::DMSCI_MODE_ASYNC && c.parity_en)
			return dmsci_pkg::DMSCI_BITS_7;
		return dmsci_pkg::DMSCI_BITS_8;
	endfunction

	assign is_sync  = (cfg.mode == dmsci_pkg::DMSCI_MODE_SYNC);    // [R17]
	assign is_multi = (cfg.mode == dmsci_pkg::DMSCI_MODE_MULTI);   // [R17]
	assign par_on   = (cfg.mode == dmsci_pkg::DMSCI_MODE_ASYNC) && cfg.parity_en; // [R05]
	assign nbits    = data_bits(cfg);

	// ****************************************************************
	// Submodules
	// ****************************************************************
	dmsci_baud u_baud (
		.sys_clk      (sys_clk),
		.rst_b        (rst_b),
		.cfg          (cfg),
		.ext_clk_sync (st_reg.ext_s[1]),
		.tmr_clk_sync (st_reg.tmr_s[1]),
		.os_tick      (os_tick)
	);

	// Transmit buffer; the shifter is the second stage. [R01]
	dmsci_fifo #(
		.WIDTH (9),
		.DEPTH (dmsci_pkg::DMSCI_FIFO_D)
	) u_txq (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   ({tx_addr, tx_data}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	assign f_ready = (st_reg.tx_st == DMSCI_IDLE) && os_tick;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		st_next        = st_reg;
		st_next.rxd_s  = {st_reg.rxd_s[0], rxd};
		st_next.ext_s  = {st_reg.ext_s[0], ext_clk_in};
		st_next.tmr_s  = {st_reg.tmr_s[0], tmr_clk_in};
		st_next.tx_irq = 1'b0;
		st_next.rx_irq = 1'b0;
		st_next.rx_ats = 1'b0;
		st_next.tx_ats = 1'b0;
		st_next.sck_oe = is_sync;
		// Core taking the word frees the receive buffer.
		if (rx_ack)
			st_next.rx_valid = 1'b0;

		// Transmitter; NRZ, line idles high. [R07]
		if (os_tick)
		begin
			case (st_reg.tx_st)
				DMSCI_IDLE:
				begin
					st_next.txd = 1'b1;
					st_next.sck = 1'b1;
					if (f_valid)
					begin
						st_next.tx_ph = '0;
						st_next.tx_bit = '0;
						st_next.tx_stop2 = cfg.two_stop;
						// Parity lands after 7 data bits; address bit after 8. [R02] [R03] [R19]
						if (par_on)
							st_next.tx_sh = {2'b11, cfg.parity_odd ^ (^f_data[6:0]),
								f_data[6:0]};
						else if (is_multi)
							st_next.tx_sh = {1'b1, f_data[8], f_data[7:0]}; // [R13]
						else
							st_next.tx_sh = {2'b11, f_data[7:0]};
						// Sync skips the start bit. [R06]
						st_next.tx_st = is_sync ? DMSCI_DATA : DMSCI_START;
						st_next.txd   = is_sync ? f_data[0] : 1'b0;
						st_next.sck   = ~is_sync;
					end
				end
				DMSCI_START, DMSCI_DATA, DMSCI_STOP:
				begin
					st_next.tx_ph = st_reg.tx_ph + 1'b1;
					if (is_sync && st_reg.tx_ph == dmsci_pkg::DMSCI_OVS_MID)
						st_next.sck = 1'b1;
					if (st_reg.tx_ph == dmsci_pkg::DMSCI_OVS_LAST)
						case (st_reg.tx_st)
							DMSCI_START:
							begin
								st_next.tx_st = DMSCI_DATA;
								st_next.txd   = st_reg.tx_sh[0];
							end
							DMSCI_DATA:
							begin
								st_next.tx_bit = st_reg.tx_bit + 1'b1;
								st_next.tx_sh  = {1'b1, st_reg.tx_sh[9:1]};
								st_next.txd    = st_reg.tx_sh[1];
								st_next.sck    = ~is_sync;
								// Sync ends after data; async adds parity or address, stop. [R06]
								if (st_reg.tx_bit == nbits - 1'b1 + 4'(par_on || is_multi)
									|| (is_sync && st_reg.tx_bit == nbits - 1'b1))
								begin
									st_next.tx_st = is_sync ? DMSCI_IDLE : DMSCI_STOP;
									st_next.txd   = 1'b1;
									st_next.sck   = 1'b1;
									if (is_sync)
									begin
										st_next.tx_irq = 1'b1;                 // [R11]
										st_next.tx_ats = auto_xfer_en;         // [R12]
									end
								end
							end
							default:
							begin
								if (st_reg.tx_stop2)
									st_next.tx_stop2 = 1'b0;
								else
								begin
									st_next.tx_st  = DMSCI_IDLE;
									st_next.tx_irq = 1'b1;                     // [R11]
									st_next.tx_ats = auto_xfer_en;             // [R12]
								end
							end
						endcase
				end
				default: st_next.tx_st = DMSCI_IDLE;
			endcase
		end

		// Receiver.
		if (os_tick)
		begin
			case (st_reg.rx_st)
				DMSCI_IDLE:
				begin
					st_next.rx_ph  = '0;
					st_next.rx_bit = '0;
					// Sync mode: data starts when the clock is ours and framed by tx.
					if (is_sync && st_reg.tx_st == DMSCI_DATA && st_reg.tx_bit == '0
						&& st_reg.tx_ph == '0)
						st_next.rx_st = DMSCI_DATA;
					else if (!is_sync && !st_reg.rxd_s[1])
						st_next.rx_st = DMSCI_START;                           // [R18]
				end
				DMSCI_START:
				begin
					st_next.rx_ph = st_reg.rx_ph + 1'b1;
					// Glitch shorter than half a bit is not a start.
					if (st_reg.rx_ph == dmsci_pkg::DMSCI_OVS_MID)
					begin
						st_next.rx_ph = '0;
						st_next.rx_st = st_reg.rxd_s[1] ? DMSCI_IDLE : DMSCI_DATA;
					end
				end
				DMSCI_DATA:
				begin
					st_next.rx_ph = st_reg.rx_ph + 1'b1;
					if (st_reg.rx_ph == dmsci_pkg::DMSCI_OVS_LAST)
					begin
						// Sample at bit centre. [R18]
						st_next.rx_sh  = {st_reg.rxd_s[1], st_reg.rx_sh[8:1]};
						st_next.rx_bit = st_reg.rx_bit + 1'b1;
						if (st_reg.rx_bit == nbits - 1'b1 + 4'(par_on || is_multi)
							|| (is_sync && st_reg.rx_bit == nbits - 1'b1))
							st_next.rx_st = is_sync ? DMSCI_IDLE : DMSCI_STOP;
						if (is_sync && st_reg.rx_bit == nbits - 1'b1)
						begin
							st_next.rx_err.overrun_err = st_reg.rx_valid && !rx_ack;
							st_next.rx_data  = {st_reg.rxd_s[1], st_reg.rx_sh[8:2]};
							st_next.rx_valid = 1'b1;
							st_next.rx_err.frame_err  = 1'b0;                  // [R08]
							st_next.rx_err.parity_err = 1'b0;                  // [R09]
							st_next.rx_irq = 1'b1;                             // [R10]
							st_next.rx_ats = auto_xfer_en;                     // [R12]
						end
					end
				end
				default:
				begin
					st_next.rx_ph = st_reg.rx_ph + 1'b1;
					if (st_reg.rx_ph == dmsci_pkg::DMSCI_OVS_LAST)
					begin
						st_next.rx_st = DMSCI_IDLE;
						st_next.rx_err.frame_err   = !st_reg.rxd_s[1];         // [R08]
						st_next.rx_err.parity_err  = par_on &&                 // [R09]
							(st_reg.rx_sh[8] ^ (^st_reg.rx_sh[7:1]) ^ cfg.parity_odd);
						st_next.rx_err.overrun_err = st_reg.rx_valid && !rx_ack;
						st_next.rx_data  = par_on ? {1'b0, st_reg.rx_sh[7:1]}
							: (is_multi ? st_reg.rx_sh[7:0] : st_reg.rx_sh[8:1]);
						st_next.rx_valid = 1'b1;
						st_next.rx_irq   = 1'b1;                               // [R10]
						st_next.rx_ats   = auto_xfer_en;                       // [R12]
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			st_reg       <= '0;
			st_reg.rxd_s <= 2'h3;
			st_reg.txd   <= 1'b1;
			st_reg.sck   <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign txd                      = st_reg.txd;
	assign sck_out                  = st_reg.sck;
	assign sck_oe                   = st_reg.sck_oe;
	assign rx_valid                 = st_reg.rx_valid;
	assign rx_data                  = st_reg.rx_data;
	assign rx_err                   = st_reg.rx_err;
	assign rx_irq                   = st_reg.rx_irq;
	assign tx_irq                   = st_reg.tx_irq;
	assign rx_auto_transfer_service = st_reg.rx_ats;
	assign tx_auto_transfer_service = st_reg.tx_ats;

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_txd_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R07]
		st_reg.tx_st == DMSCI_IDLE && $past(st_reg.tx_st) == DMSCI_IDLE |-> txd)
		else $error("Transmit line not high while idle.");
	chk_sync_no_start: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R06]
		is_sync |-> st_reg.tx_st != DMSCI_START)
		else $error("Start bit produced in sync mode.");
	chk_par_off: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R09]
		!par_on && st_reg.rx_irq |-> !rx_err.parity_err)
		else $error("Parity error outside normal async.");
	chk_frame_sync: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R08]
		is_sync && $past(is_sync) && st_reg.rx_irq |-> !rx_err.frame_err)
		else $error("Framing error in sync mode.");
	chk_rx_irq_valid: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
		rx_irq |-> rx_valid)
		else $error("Receive interrupt without buffered data.");
	chk_tx_irq_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
		tx_irq |=> !tx_irq)
		else $error("Transmit interrupt longer than one cycle.");
	chk_ats_follow: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12]
		rx_auto_transfer_service |-> rx_irq)
		else $error("Receive transfer request without interrupt.");
	chk_bits_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R04]
		(is_sync || is_multi) |-> nbits == dmsci_pkg::DMSCI_BITS_8)
		else $error("Data length not eight in multi or sync mode.");
	cov_tx_done: cover property (@(posedge sys_clk) disable iff (!rst_b) tx_irq);
	cov_rx_frame: cover property (@(posedge sys_clk) disable iff (!rst_b)
		rx_irq && rx_err.frame_err);
	cov_sync_rx: cover property (@(posedge sys_clk) disable iff (!rst_b) is_sync && rx_irq);
endmodule

//--- tb/dmsci_partner.sv
// Purpose: Far-side serial device for the serial comm interface bench.
// Assumes: Async bit time in ns is set by the bench; the line idles high.
// Notes:   Async frames land in got LSB first; clocked bits shift in at got[10].
module dmsci_partner (
	// Serial pins
	input  wire logic txd,
	input  wire logic sck_out,
	input  wire logic sck_oe,
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	int          bit_ns = 640;
	int          nbits = 9;
	int          nsck = 0;
	logic [10:0] got = '0;
	logic [7:0]  sbuf = '0;

	// Start edge, then each bit read at its centre.
	initial
	begin
		rxd = 1'b1;
		forever
		begin
			@(negedge txd);
			if (!sck_oe)
			begin
				got = '0;
				#(bit_ns / 2);
				for (int k = 0; k < nbits; k++)
				begin
					#(bit_ns);
					got[k] = txd;
				end
			end
		end
	end

	// Clocked mode: the interface takes each bit a tick after the falling clock,
	// so drive on the rising clock, which also captures txd.
	always @(posedge sck_out)
		if (sck_oe)
		begin
			rxd <= sbuf[0];
			sbuf <= {~sbuf[0], sbuf[7:1]};
			got <= {txd, got[10:1]};
			nsck <= nsck + 1;
		end

	// Start bit, then n bits LSB first; the line goes back to idle high.
	task automatic send(input logic [10:0] b, input int n);
		rxd = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			#(bit_ns);
			rxd = b[i];
		end
		#(bit_ns);
		rxd = 1'b1;
	endtask
endmodule

//--- tb/test_dmsci_top.sv
// Purpose: Self-checking bench for the dual mode serial comm interface.
// Assumes: The outside bit clock gives one x16 tick every four cycles.
// Notes:   Table rows cover async and multi modes and receive errors; hand tests follow.
module test_dmsci_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Flags fl hold parity enable, odd, two stops and address bit.
	typedef struct
	{
		logic [1:0]  mode;
		logic [1:0]  clk;
		logic [3:0]  fl;
		logic [7:0]  d;
		logic [10:0] f;
		logic [3:0]  n;
		logic [10:0] s;
		logic [7:0]  r;
		logic [2:0]  e;
		logic        ack;
	} dmsci_row_s;
	logic                  sys_clk = 1'b0;
	logic                  rst_b = 1'b0;
	dmsci_pkg::dmsci_cfg_s cfg = '0;
	logic                  ext_clk_in = 1'b0;
	logic                  tmr_clk_in = 1'b0;
	logic                  auto_xfer_en = 1'b1;
	logic                  tx_valid = 1'b0;
	logic [7:0]            tx_data = '0;
	logic                  tx_addr = 1'b0;
	logic                  rx_ack = 1'b0;
	logic [7:0]            rx_data;
	dmsci_pkg::dmsci_err_s rx_err;
	logic                  tx_ready, rx_valid, rx_irq, tx_irq, rx_ats, tx_ats;
	logic                  rxd, txd, sck_out, sck_oe;
	logic [1:0]            oc = '0;
	int                    n_mismatch = 0;
	int                    checked = 0;
	int                    t, acc;
	dmsci_row_s            rows [10] = '{
		'{2'h0, 2'h1, 4'h0, 8'ha5, 11'h1a5, 4'h9, 11'h1a5, 8'ha5, 3'h0, 1'h1},
		'{2'h0, 2'h1, 4'ha, 8'h53, 11'h353, 4'ha, 11'h353, 8'h53, 3'h0, 1'h1},
		'{2'h0, 2'h1, 4'hc, 8'hc1, 11'h1c1, 4'h9, 11'h1c1, 8'h41, 3'h0, 1'h1},
		'{2'h1, 2'h1, 4'h1, 8'h3c, 11'h33c, 4'ha, 11'h33c, 8'h3c, 3'h0, 1'h1},
		'{2'h1, 2'h1, 4'ha, 8'h81, 11'h681, 4'hb, 11'h681, 8'h81, 3'h0, 1'h1},
		'{2'h0, 2'h2, 4'h2, 8'h00, 11'h300, 4'ha, 11'h300, 8'h00, 3'h0, 1'h1},
		'{2'h0, 2'h1, 4'h0, 8'ha5, 11'h1a5, 4'h9, 11'h0a5, 8'ha5, 3'h4, 1'h1},
		'{2'h0, 2'h1, 4'h8, 8'h53, 11'h153, 4'h9, 11'h1d3, 8'h53, 3'h1, 1'h1},
		'{2'h0, 2'h1, 4'h0, 8'h11, 11'h111, 4'h9, 11'h111, 8'h11, 3'h0, 1'h0},
		'{2'h0, 2'h1, 4'h0, 8'h22, 11'h122, 4'h9, 11'h122, 8'h22, 3'h2, 1'h1}};

	dmsci_top uut (.sys_clk, .rst_b, .cfg, .ext_clk_in, .tmr_clk_in, .auto_xfer_en,
		.tx_valid, .tx_ready, .tx_data, .tx_addr, .rx_valid, .rx_ack, .rx_data,
		.rx_err, .rx_irq, .tx_irq, .rx_auto_transfer_service(rx_ats),
		.tx_auto_transfer_service(tx_ats), .rxd, .txd, .sck_out, .sck_oe);
	dmsci_partner p (.txd, .sck_out, .sck_oe, .rxd);

	// ****************************************************************
	// Clocks, checking and closing
	// ****************************************************************
	initial
	begin
		forever
			#5 sys_clk = ~sys_clk;
	end
	// Outside bit clocks share one divider so both sources run at one rate.
	always @(posedge sys_clk)
	begin
		#1;
		oc = oc + 2'h1;
		ext_clk_in = oc[1];
		tmr_clk_in = oc[1];
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// The run needs about 46k cycles, so 100k means a hang.
	initial
	begin
		#1000000;
		n_mismatch++;
		stop_test();
	end

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic put(input logic [7:0] d);
		tx_data = d;
		tx_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		tx_valid = 1'b0;
	endtask
	task automatic wait_irq(input logic rx);
		int k;
		for (k = 0; k < 40000 && (rx ? rx_irq : tx_irq) !== 1'b1; k++)
		begin
			@(posedge sys_clk);
			#1;
		end
		check("irq", 16'(k < 40000), 16'h1);
		check("auto", 16'(rx ? rx_ats : tx_ats), 16'(auto_xfer_en));
	endtask
	task automatic ack;
		rx_ack = 1'b1;
		@(posedge sys_clk);
		#1;
		rx_ack = 1'b0;
		check("rx_clear", 16'(rx_valid), 16'h0);
	endtask
	// One character each way with the row's settings.
	task automatic run_row(input dmsci_row_s r);
		cfg.mode = dmsci_pkg::dmsci_mode_e'(r.mode);
		cfg.clk_sel = dmsci_pkg::dmsci_clksel_e'(r.clk);
		{cfg.parity_en, cfg.parity_odd, cfg.two_stop, tx_addr} = r.fl;
		p.nbits = int'(r.n);
		put(r.d);
		wait_irq(1'b0);
		check("tx_frame", 16'(p.got), 16'(r.f));
		fork
			p.send(r.s, int'(r.n));
			wait_irq(1'b1);
		join
		check("rx_data", 16'(rx_data), 16'(r.r));
		check("rx_err", 16'(rx_err), 16'(r.e));
		check("rx_valid", 16'(rx_valid), 16'h1);
		if (r.ack)
			ack();
	endtask

	// Main sequence: reset, table, then the hand-written cases.
	initial
	begin
		repeat (16) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		check("reset", 16'({txd, sck_out, sck_oe, tx_ready, rx_valid, rx_irq}), 16'h34);
		foreach (rows[i])
			run_row(rows[i]);
		// Dedicated generator at the fastest async rate: 3200 cycles a bit.
		cfg = '{dmsci_pkg::DMSCI_MODE_ASYNC, dmsci_pkg::DMSCI_CLK_BAUD, 3'h0, 1'b0, 1'b0, 1'b0};
		p.bit_ns = 32000;
		p.nbits = 9;
		put(8'hff);
		for (t = 0; t < 5000 && txd !== 1'b0; t++)
		begin
			@(posedge sys_clk);
			#1;
		end
		for (t = 0; t < 5000 && txd === 1'b0; t++)
		begin
			@(posedge sys_clk);
			#1;
		end
		check("start_len", 16'(t), 16'd3200);
		wait_irq(1'b0);
		check("baud_frame", 16'(p.got), 16'h1ff);
		// Clocked mode: eight clocks, data only, both ways at once.
		cfg.mode = dmsci_pkg::DMSCI_MODE_SYNC;
		cfg.clk_sel = dmsci_pkg::DMSCI_CLK_EXT;
		cfg.parity_en = 1'b1;
		auto_xfer_en = 1'b0;
		p.sbuf = 8'h96;
		p.nsck = 0;
		put(8'h69);
		fork
			wait_irq(1'b0);
			wait_irq(1'b1);
		join
		check("sync_tx", 16'(p.got[10:3]), 16'h69);
		check("sck_count", 16'(p.nsck), 16'h8);
		check("sync_rx", 16'({rx_data, rx_err, sck_oe}), 16'(12'h961));
		ack();
		// Fill the transmit buffer until it refuses.
		p.rxd = 1'b1;
		cfg.mode = dmsci_pkg::DMSCI_MODE_ASYNC;
		p.bit_ns = 640;
		acc = 0;
		tx_valid = 1'b1;
		repeat (40)
		begin
			acc += int'(tx_ready === 1'b1);
			@(posedge sys_clk);
			#1;
		end
		check("fifo_full", 16'(tx_ready), 16'h0);
		check("fifo_count", 16'(acc >= 32 && acc <= 33), 16'h1);
		tx_valid = 1'b0;
		stop_test();
	end
endmodule
